// *** inc/ssa_map.svh ***
// Register map, field positions, reset values and timing constants
// Operation
// - Result is unsigned eight bits, 0 to 255
// - Comparator high while ramp below held input
// - Count data clocks from ramp start to trip
// - High phase spans high_len ticks of div_len+1 counts, 256 at reset
// - Low phase discharges the ramp capacitor
// - Terminal count raises the result interrupt
// - Control bit 7 flags count above 255
// - Timing generator clocked only by divided clock
// - Waveform holds sample-hold during the high phase only
// - One timing generator shared by both columns
// - Each column has its own trim register
// - Trim holds eight-bit capacitance value field
// - High and low durations programmable in divided clock ticks
`ifndef SSA_MAP_SVH
`define SSA_MAP_SVH

`define SSA_ADDR_CTRL        12'h000
`define SSA_ADDR_RESULT      12'h004
`define SSA_ADDR_TRIM0       12'h008
`define SSA_ADDR_TRIM1       12'h00c
`define SSA_ADDR_TIMING      12'h010
`define SSA_ADDR_IRQ_STATUS  12'h014
`define SSA_ADDR_IRQ_ENABLE  12'h018
`define SSA_ADDR_IRQ_CLEAR   12'h01c

`define SSA_CTRL_ENABLE      0
`define SSA_CTRL_COLUMN      1
`define SSA_CTRL_OVERFLOW    7

`define SSA_IRQ_DONE         0
`define SSA_IRQ_OVERFLOW     1

`define SSA_TIM_HIGH_LSB     0
`define SSA_TIM_LOW_LSB      8
`define SSA_TIM_DIV_LSB      16

`define SSA_TRIM_RESET       8'h80
`define SSA_HIGH_RESET       8'h01
`define SSA_LOW_RESET        8'h01
`define SSA_DIV_RESET        8'hff
`define SSA_FULL_COUNT       9'h100
`define SSA_MAX_CODE         8'hff

`endif

// *** inc/ssa_pkg.sv ***
// Types shared by the single slope converter control logic
package ssa_pkg;

	typedef enum logic [1:0] {
		SSA_IDLE,
		SSA_MEASURE,
		SSA_DISCHARGE
	} ssa_phase_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} ssa_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} ssa_apb_rsp_t;

	typedef struct packed {
		logic       ramp_run;
		logic       discharge;
		logic       hold;
		logic       column;
		logic [7:0] trim;
	} ssa_analog_t;

	typedef struct packed {
		ssa_phase_t  phase;
		logic        enable;
		logic        column;
		logic        overflow;
		logic [7:0]  result;
		logic [7:0]  trim0;
		logic [7:0]  trim1;
		logic [7:0]  high_len;
		logic [7:0]  low_len;
		logic [7:0]  div_len;
		logic [7:0]  div_cnt;
		logic [7:0]  phase_cnt;
		logic [8:0]  count;
		logic        tripped;
		logic [1:0]  irq_status;
		logic [1:0]  irq_enable;
		logic        cmp_meta;
		logic        cmp_sync;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ssa_state_t;

endpackage

// *** design/ssa_converter.sv ***
// Single slope converter timing, counter and register logic
`timescale 1ns/1ps
`include "ssa_map.svh"

module ssa_converter
	import ssa_pkg::*;
(
	// Clock and reset
	input  wire logic         core_clk_in,
	input  wire logic         reset_in,
	// APB slave
	input  wire ssa_apb_req_t apb_req_in,
	output ssa_apb_rsp_t      apb_rsp_out,
	// Analog side
	input  wire logic         comparator_in,
	output ssa_analog_t       analog_out,
	// Interrupt
	output logic              irq_out
);

	ssa_state_t s_q;
	ssa_state_t s_d;

	logic       div_tick;
	logic       phase_end;
	logic       setup;
	logic       acc;
	logic [7:0] phase_len;
	logic [7:0] cur_trim;

	// Divided clock tick: one core cycle in div_len+1
	assign div_tick  = (s_q.div_cnt == s_q.div_len);
	assign phase_len = (s_q.phase == SSA_MEASURE) ? s_q.high_len
		: s_q.low_len;
	assign phase_end = div_tick && (s_q.phase_cnt == phase_len);
	assign setup     = apb_req_in.psel && !apb_req_in.penable;
	assign acc       = apb_req_in.psel && apb_req_in.penable;
	assign cur_trim  = s_q.column ? s_q.trim1 : s_q.trim0;

	always_comb
	begin
		s_d = s_q;
		// Comparator is asynchronous to the core clock
		s_d.cmp_meta = comparator_in;
		s_d.cmp_sync = s_q.cmp_meta;
		s_d.pready   = 1'b0;
		s_d.pslverr  = 1'b0;

		// Divided clock runs always; the timing generator uses only it
		s_d.div_cnt = div_tick ? 8'h00 : s_q.div_cnt + 8'h01;
		if (div_tick)
			s_d.phase_cnt = s_q.phase_cnt + 8'h01;

		unique case (s_q.phase)
			SSA_IDLE:
			begin
				s_d.phase_cnt = 8'h01;
				if (s_q.enable && div_tick)
				begin
					s_d.phase   = SSA_MEASURE;
					s_d.count   = 9'h000;
					s_d.tripped = 1'b0;
				end
			end
			SSA_MEASURE:
			begin
				// Count every data clock until the comparator trips;
				// stop at 256 so a long high phase cannot wrap the count
				if (s_q.cmp_sync && !s_q.tripped
					&& s_q.count != `SSA_FULL_COUNT)
					s_d.count = s_q.count + 9'h001;
				if (!s_q.cmp_sync)
					s_d.tripped = 1'b1;
				if (phase_end)
				begin
					s_d.phase     = SSA_DISCHARGE;
					s_d.phase_cnt = 8'h01;
					// Reaching 256 counts means the input is out of range
					s_d.overflow  =
						(s_d.count == `SSA_FULL_COUNT);
					s_d.result    = (s_d.overflow) ? `SSA_MAX_CODE
						: s_d.count[7:0];
					// Terminal count of the timing generator
					s_d.irq_status[`SSA_IRQ_DONE] = 1'b1;
					if (s_d.overflow)
						s_d.irq_status[`SSA_IRQ_OVERFLOW] = 1'b1;
				end
			end
			SSA_DISCHARGE:
			begin
				if (phase_end)
				begin
					s_d.phase_cnt = 8'h01;
					s_d.phase     = s_q.enable ? SSA_MEASURE : SSA_IDLE;
					s_d.count     = 9'h000;
					s_d.tripped   = 1'b0;
				end
			end
			default:
				s_d.phase = SSA_IDLE;
		endcase

		// APB: answer in the cycle after the first access cycle
		if (acc && !s_q.pready)
		begin
			s_d.pready = 1'b1;
			s_d.prdata = 32'h0000_0000;
			unique case (apb_req_in.paddr)
				`SSA_ADDR_CTRL:
				begin
					s_d.prdata[`SSA_CTRL_ENABLE]   = s_q.enable;
					s_d.prdata[`SSA_CTRL_COLUMN]   = s_q.column;
					s_d.prdata[`SSA_CTRL_OVERFLOW] = s_q.overflow;
					if (apb_req_in.pwrite)
					begin
						s_d.enable = apb_req_in.pwdata[`SSA_CTRL_ENABLE];
						// Column changes only while idle: one timing generator
						if (s_q.phase == SSA_IDLE)
							s_d.column =
								apb_req_in.pwdata[`SSA_CTRL_COLUMN];
					end
				end
				`SSA_ADDR_RESULT:
					s_d.prdata[7:0] = s_q.result;
				`SSA_ADDR_TRIM0:
				begin
					s_d.prdata[7:0] = s_q.trim0;
					if (apb_req_in.pwrite)
						s_d.trim0 = apb_req_in.pwdata[7:0];
				end
				`SSA_ADDR_TRIM1:
				begin
					s_d.prdata[7:0] = s_q.trim1;
					if (apb_req_in.pwrite)
						s_d.trim1 = apb_req_in.pwdata[7:0];
				end
				`SSA_ADDR_TIMING:
				begin
					s_d.prdata[`SSA_TIM_HIGH_LSB +: 8] = s_q.high_len;
					s_d.prdata[`SSA_TIM_LOW_LSB +: 8]  = s_q.low_len;
					s_d.prdata[`SSA_TIM_DIV_LSB +: 8]  = s_q.div_len;
					// Timing is frozen while a conversion is running
					if (apb_req_in.pwrite && s_q.phase == SSA_IDLE)
					begin
						s_d.high_len = apb_req_in.pwdata[`SSA_TIM_HIGH_LSB +: 8];
						s_d.low_len  = apb_req_in.pwdata[`SSA_TIM_LOW_LSB +: 8];
						s_d.div_len  = apb_req_in.pwdata[`SSA_TIM_DIV_LSB +: 8];
					end
				end
				`SSA_ADDR_IRQ_STATUS:
					s_d.prdata[1:0] = s_q.irq_status;
				`SSA_ADDR_IRQ_ENABLE:
				begin
					s_d.prdata[1:0] = s_q.irq_enable;
					if (apb_req_in.pwrite)
						s_d.irq_enable = apb_req_in.pwdata[1:0];
				end
				`SSA_ADDR_IRQ_CLEAR:
				begin
					// New events win over a clear in the same cycle
					if (apb_req_in.pwrite)
						s_d.irq_status = s_d.irq_status
							& ~(apb_req_in.pwdata[1:0] & ~(s_d.irq_status
							& ~s_q.irq_status));
				end
				default:
					s_d.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			s_q            <= '0;
			s_q.phase      <= SSA_IDLE;
			s_q.trim0      <= `SSA_TRIM_RESET;
			s_q.trim1      <= `SSA_TRIM_RESET;
			s_q.high_len   <= `SSA_HIGH_RESET;
			s_q.low_len    <= `SSA_LOW_RESET;
			s_q.div_len    <= `SSA_DIV_RESET;
		end
		else
			s_q <= s_d;
	end

	assign apb_rsp_out.pready  = s_q.pready;
	assign apb_rsp_out.pslverr = s_q.pslverr;
	assign apb_rsp_out.prdata  = s_q.prdata;

	// Ramp runs in the high phase, discharge in the low phase
	assign analog_out.ramp_run  = (s_q.phase == SSA_MEASURE);
	assign analog_out.discharge = (s_q.phase != SSA_MEASURE);
	assign analog_out.hold      = (s_q.phase == SSA_MEASURE);
	assign analog_out.column    = s_q.column;
	assign analog_out.trim      = cur_trim;

	assign irq_out = |(s_q.irq_status & s_q.irq_enable);

	// Assertions
	sequence s_measure_end;
		s_q.phase == SSA_MEASURE && phase_end;
	endsequence

	property p_done_irq;
		@(posedge core_clk_in) disable iff (reset_in)
		s_measure_end |=> s_q.irq_status[`SSA_IRQ_DONE];
	endproperty
	a_done_irq: assert property (p_done_irq)
		else $error("done flag not set at terminal count");

	property p_clear_start;
		@(posedge core_clk_in) disable iff (reset_in)
		$rose(s_q.phase == SSA_MEASURE) |-> s_q.count == 9'h000;
	endproperty
	a_clear_start: assert property (p_clear_start)
		else $error("count not zero at measure start");

	property p_discharge;
		@(posedge core_clk_in) disable iff (reset_in)
		s_q.phase == SSA_DISCHARGE |-> analog_out.discharge
			&& !analog_out.ramp_run;
	endproperty
	a_discharge: assert property (p_discharge)
		else $error("ramp not discharged in low phase");

	property p_overflow;
		@(posedge core_clk_in) disable iff (reset_in)
		s_measure_end ##0 (s_q.cmp_sync && !s_q.tripped
			&& s_q.count >= `SSA_MAX_CODE) |=> s_q.overflow;
	endproperty
	a_overflow: assert property (p_overflow)
		else $error("overflow not flagged");

	property p_result;
		@(posedge core_clk_in) disable iff (reset_in)
		s_measure_end ##0 s_q.tripped |=> s_q.result == $past(s_q.count[7:0]);
	endproperty
	a_result: assert property (p_result)
		else $error("result differs from count");

	property p_count_stop;
		@(posedge core_clk_in) disable iff (reset_in)
		s_q.phase == SSA_MEASURE && s_q.tripped && !phase_end
			|=> $stable(s_q.count);
	endproperty
	a_count_stop: assert property (p_count_stop)
		else $error("count moved after comparator trip");

	property p_hold;
		@(posedge core_clk_in) disable iff (reset_in)
		s_q.phase == SSA_MEASURE |-> analog_out.hold;
	endproperty
	a_hold: assert property (p_hold)
		else $error("sample not held in measure phase");

	property p_div;
		@(posedge core_clk_in) disable iff (reset_in)
		div_tick |=> s_q.div_cnt == 8'h00;
	endproperty
	a_div: assert property (p_div)
		else $error("divider did not wrap");

	property p_column;
		@(posedge core_clk_in) disable iff (reset_in)
		s_q.phase != SSA_IDLE && s_d.phase != SSA_IDLE |=> $stable(s_q.column);
	endproperty
	a_column: assert property (p_column)
		else $error("column changed mid conversion");

	sequence s_discharge_end;
		s_q.phase == SSA_DISCHARGE && phase_end;
	endsequence

	property p_count_run;
		@(posedge core_clk_in) disable iff (reset_in)
		s_q.phase == SSA_MEASURE && s_q.cmp_sync && !s_q.tripped
			&& s_q.count != `SSA_FULL_COUNT
			|=> s_q.count == $past(s_q.count) + 9'h001;
	endproperty
	a_count_run: assert property (p_count_run)
		else $error("count did not advance before trip");

	property p_trip;
		@(posedge core_clk_in) disable iff (reset_in)
		s_q.phase == SSA_MEASURE && !s_q.cmp_sync |=> s_q.tripped;
	endproperty
	a_trip: assert property (p_trip)
		else $error("comparator low not taken as trip");

	property p_ovf_result;
		@(posedge core_clk_in) disable iff (reset_in)
		s_measure_end ##1 s_q.overflow |-> s_q.result == `SSA_MAX_CODE;
	endproperty
	a_ovf_result: assert property (p_ovf_result)
		else $error("overflow result not saturated");

	property p_to_discharge;
		@(posedge core_clk_in) disable iff (reset_in)
		s_measure_end |=> s_q.phase == SSA_DISCHARGE;
	endproperty
	a_to_discharge: assert property (p_to_discharge)
		else $error("high phase did not end in discharge");

	property p_count_clear;
		@(posedge core_clk_in) disable iff (reset_in)
		s_discharge_end |=> s_q.count == 9'h000 && !s_q.tripped;
	endproperty
	a_count_clear: assert property (p_count_clear)
		else $error("count not cleared for next high phase");

	property p_irq_level;
		@(posedge core_clk_in) disable iff (reset_in)
		s_q.irq_status[`SSA_IRQ_DONE] && s_q.irq_enable[`SSA_IRQ_DONE]
			|-> irq_out;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("enabled done flag without interrupt");

	property p_div_step;
		@(posedge core_clk_in) disable iff (reset_in)
		!div_tick |=> s_q.div_cnt == $past(s_q.div_cnt) + 8'h01;
	endproperty
	a_div_step: assert property (p_div_step)
		else $error("divider skipped a step");

	property p_trim_sel;
		@(posedge core_clk_in) disable iff (reset_in)
		!s_q.column |-> analog_out.trim == s_q.trim0;
	endproperty
	a_trim_sel: assert property (p_trim_sel)
		else $error("column zero trim not driven");

	property p_timing_frozen;
		@(posedge core_clk_in) disable iff (reset_in)
		s_q.phase != SSA_IDLE |=> $stable(s_q.high_len)
			&& $stable(s_q.low_len) && $stable(s_q.div_len);
	endproperty
	a_timing_frozen: assert property (p_timing_frozen)
		else $error("timing changed during conversion");

	property p_ready_pulse;
		@(posedge core_clk_in) disable iff (reset_in)
		apb_rsp_out.pready |=> !apb_rsp_out.pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready held longer than one cycle");

	property p_slverr;
		@(posedge core_clk_in) disable iff (reset_in)
		apb_rsp_out.pslverr |-> apb_rsp_out.pready;
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("error response without ready");

endmodule

// *** tb/ssa_ramp_model.sv ***
// Behavioural ramp, comparator and sample-hold beside the converter
`timescale 1ns/1ps

module ssa_ramp_model
	import ssa_pkg::*;
(
	// Clock
	input  wire logic        core_clk_in,
	// Controls from the converter
	input  wire ssa_analog_t analog_in,
	input  wire logic [15:0] trip_in,
	// Comparator level
	output logic             comparator_out
);
	logic [15:0] ramp_q;

	// Ramp only rises while running; discharge empties it
	always @(posedge core_clk_in)
	begin
		if (analog_in.discharge)
			ramp_q <= 16'h0000;
		else if (analog_in.ramp_run && analog_in.hold)
			ramp_q <= ramp_q + 16'h0001;
	end

	// High until the ramp passes the held input
	assign comparator_out = (ramp_q < trip_in);

	initial ramp_q = 16'h0000;
endmodule

// *** tb/single_slope_adc_timing_counter_test.sv ***
// Self-checking bench for the single slope converter control
`timescale 1ns/1ps
`include "ssa_map.svh"

module single_slope_adc_timing_counter_test
	import ssa_pkg::*;
;
	logic         clk;
	logic         rst;
	ssa_apb_req_t req;
	ssa_apb_rsp_t rsp;
	logic         cmp;
	ssa_analog_t  an;
	logic         irq;
	logic [15:0]  trip;
	int           fails;
	int           n_checks;
	int           cyc;
	logic [31:0]  rd;
	logic         er;

	ssa_converter u_dut (
		.core_clk_in  (clk),
		.reset_in     (rst),
		.apb_req_in   (req),
		.apb_rsp_out  (rsp),
		.comparator_in(cmp),
		.analog_out   (an),
		.irq_out      (irq)
	);

	ssa_ramp_model u_ramp (
		.core_clk_in   (clk),
		.analog_in     (an),
		.trip_in       (trip),
		.comparator_out(cmp)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Long enough for several 512-cycle conversions
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			close_out();
		end
	end

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Waits for ready however long; only the bench timeout ends a hang
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask

	task automatic t_reset();
		apb(1'b0, `SSA_ADDR_TRIM0, 32'h0);
		chk("trim0", 32'h0000_0080, rd);
		apb(1'b0, `SSA_ADDR_TIMING, 32'h0);
		chk("timing", 32'h00ff_0101, rd);
		chk("discharge", 32'h1, {31'h0, an.discharge});
		chk("irq", 32'h0, {31'h0, irq});
		$display("reset test done");
	endtask

	task automatic t_regs();
		apb(1'b1, `SSA_ADDR_TRIM0, 32'h0000_005a);
		apb(1'b1, `SSA_ADDR_TRIM1, 32'h0000_00a5);
		apb(1'b0, `SSA_ADDR_TRIM1, 32'h0);
		chk("trim1", 32'h0000_00a5, rd);
		chk("trim out col0", 32'h5a, {24'h0, an.trim});
		apb(1'b1, `SSA_ADDR_CTRL, 32'h0000_0002);
		@(posedge clk);
		chk("trim out col1", 32'ha5, {24'h0, an.trim});
		chk("column out", 32'h1, {31'h0, an.column});
		apb(1'b1, `SSA_ADDR_CTRL, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		$display("register test done");
	endtask

	// One conversion; a trip beyond the window never trips
	task automatic t_conv(logic [15:0] t, logic ovf);
		trip <= t;
		apb(1'b1, `SSA_ADDR_IRQ_ENABLE, 32'h0000_0003);
		apb(1'b1, `SSA_ADDR_CTRL, 32'h0000_0001);
		while (an.ramp_run !== 1'b1)
		begin
			@(posedge clk);
		end
		#1;
		chk("hold", 32'h1, {31'h0, an.hold});
		chk("no discharge", 32'h0, {31'h0, an.discharge});
		while (irq !== 1'b1)
		begin
			@(posedge clk);
		end
		apb(1'b1, `SSA_ADDR_CTRL, 32'h0);
		apb(1'b0, `SSA_ADDR_IRQ_STATUS, 32'h0);
		chk("status", {30'h0, ovf, 1'b1}, rd);
		apb(1'b0, `SSA_ADDR_CTRL, 32'h0);
		chk("ovf bit", {24'h0, ovf, 7'h0}, rd & 32'h80);
		apb(1'b0, `SSA_ADDR_RESULT, 32'h0);
		if (ovf)
			chk("sat result", 32'hff, rd);
		else
			chk("result near", 32'h1, {31'h0, rd >= t && rd <= t + 4});
		apb(1'b1, `SSA_ADDR_IRQ_CLEAR, 32'h0000_0003);
		apb(1'b0, `SSA_ADDR_IRQ_STATUS, 32'h0);
		chk("cleared", 32'h0, rd);
		chk("irq low", 32'h0, {31'h0, irq});
		$display("conversion test done trip %0d", t);
	endtask

	// Another high/divider split of the same 256-count window, irq masked
	task automatic t_timing();
		int n;
		n = 0;
		trip <= 16'd1000;
		repeat (300) @(posedge clk);
		apb(1'b1, `SSA_ADDR_IRQ_ENABLE, 32'h0);
		apb(1'b1, `SSA_ADDR_TIMING, 32'h003f_0104);
		apb(1'b0, `SSA_ADDR_TIMING, 32'h0);
		chk("timing written", 32'h003f_0104, rd);
		apb(1'b1, `SSA_ADDR_CTRL, 32'h0000_0001);
		while (an.ramp_run !== 1'b1)
		begin
			@(posedge clk);
		end
		while (an.ramp_run === 1'b1)
		begin
			@(posedge clk);
			n++;
		end
		chk("high length", 32'h100, n);
		apb(1'b1, `SSA_ADDR_CTRL, 32'h0);
		apb(1'b0, `SSA_ADDR_IRQ_STATUS, 32'h0);
		chk("masked status", 32'h3, rd);
		chk("masked irq", 32'h0, {31'h0, irq});
		apb(1'b1, `SSA_ADDR_IRQ_CLEAR, 32'h0000_0003);
		$display("timing test done");
	endtask

	initial
	begin
		rst = 1'b1;
		req = '0;
		trip = 16'h0000;
		fails = 0;
		n_checks = 0;
		cyc = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_conv(16'd100, 1'b0);
		t_conv(16'd3, 1'b0);
		t_conv(16'd1000, 1'b1);
		t_timing();
		close_out();
	end
endmodule
